//--- src/acmp_pkg.sv
package acmp_pkg;

	// ----------------------------------------------------------------
	// register offsets (printed offsets are not all multiples of four)
	// ----------------------------------------------------------------
	localparam logic [7:0] idx_converter_control_b       = 8'h03;
	localparam logic [7:0] idx_comparator_control_status = 8'h08;
	localparam logic [7:0] idx_digital_input_disable_0   = 8'h14;
	localparam logic [7:0] idx_converter_control_a       = 8'h20;
	localparam logic [7:0] idx_converter_mux_select      = 8'h21;
	localparam logic [7:0] idx_irq_status                = 8'h30;
	localparam logic [7:0] idx_irq_clear                 = 8'h31;
	localparam logic [7:0] idx_irq_enable                = 8'h32;
	localparam logic [7:0] idx_processor_status_word     = 8'h33;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int ccb_mux_enable_bit  = 6;
	localparam int cca_conv_enable_bit = 7;
	localparam int ccs_power_off_bit   = 7;
	localparam int ccs_bandgap_bit     = 6;
	localparam int ccs_result_bit      = 5;
	localparam int ccs_flag_bit        = 4;
	localparam int ccs_irq_enable_bit  = 3;
	localparam int psw_global_ie_bit   = 7;

	// ----------------------------------------------------------------
	// writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ccb_write_mask  = 8'hE7;
	localparam logic [7:0] ccs_write_mask  = 8'hCB;
	localparam logic [7:0] did_write_mask  = 8'h3F;
	localparam logic [7:0] reg8_reset      = 8'h00;
	localparam logic [0:0] irq_bits_reset  = 1'h0;
	localparam int         sync_stages     = 2;

	typedef enum logic [1:0] {
		mode_toggle  = 2'h0,
		mode_reserve = 2'h1,
		mode_fall    = 2'h2,
		mode_rise    = 2'h3
	} event_mode_e;

	typedef enum logic [2:0] {
		neg_pin = 3'h4,
		neg_ch0 = 3'h0,
		neg_ch1 = 3'h1,
		neg_ch2 = 3'h2,
		neg_ch3 = 3'h3
	} neg_sel_e;

	typedef struct packed {
		logic       power_off;
		logic       bandgap_select;
		logic [2:0] neg_select;
	} analog_ctrl_s;

	typedef struct packed {
		logic [7:0]             conv_b;
		logic [7:0]             ctrl;
		logic [7:0]             did0;
		logic [7:0]             conv_a;
		logic [7:0]             mux_sel;
		logic [7:0]             psw;
		logic [sync_stages-1:0] sync;
		logic                   result_d;
		logic                   flag;
		logic                   sticky;
		logic                   sticky_en;
		logic                   irq;
		logic                   sticky_irq;
		analog_ctrl_s           ana;
		logic [1:0]             pin_meta;
		logic [1:0]             pin_sync;
		logic [1:0]             pin_in;
		logic                   pready;
		logic [31:0]            prdata;
		logic                   pslverr;
	} state_s;

endpackage

//--- src/analog_comparator_control.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// R01: raw comparator output passes two flops; result bit lags one to two cycles.
// R02: mux enabled and converter off: channel select 00..11 picks channel 0..3.
// R03: mux disabled or converter on: dedicated negative pin used.
// R04: bandgap select one: internal bandgap drives positive input.
// R05: bandgap select zero: positive pin drives positive input.
// R06: power-off bit 7 of control powers comparator down, writable any time.
// R07: event flag set when synchronized transition matches selected mode.
// R08: interrupt requested while flag, comparator enable and global enable set.
// R09: comparator interrupt enable zero blocks the request.
// R10: taking the interrupt vector clears the event flag.
// R11: writing one to flag clears it; zero leaves it.
// R12: mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// R13: software disables interrupt before changing event mode.
// R14: software disables interrupt before changing power-off bit.
// R15: buffer-off bits 1:0 force that pin's digital input to zero.
// R16: control bit 2 reads zero, writes ignored.
// R17: converter enable bit lives in converter control A; mux needs it zero.
// R18: edge detect compares result with previous cycle, one-cycle pulse.
module analog_comparator_control (
	input  wire logic                 ref_clk,
	input  wire logic                 srst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [9:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	input  wire logic                 cmp_raw,
	input  wire logic                 pos_pin_digital,
	input  wire logic                 neg_pin_digital,
	input  wire logic                 vector_taken,
	output acmp_pkg::analog_ctrl_s    analog_ctrl,
	output logic [1:0]                pin_digital_in,
	output logic                      cmp_irq,
	output logic                      irq
);

	acmp_pkg::state_s st_r;
	acmp_pkg::state_s st_nxt;

	logic       cmp_result;
	logic       edge_pulse;
	logic       rise;
	logic       fall;
	logic       wr;
	logic       rd;
	logic [7:0] idx;
	logic [7:0] wb;
	logic [7:0] rdata;
	logic       hit;
	logic [1:0] pin_gated;

	// ----------------------------------------------------------------
	// event detection
	// ----------------------------------------------------------------
	assign cmp_result = st_r.sync[acmp_pkg::sync_stages-1]; // R01
	assign rise = cmp_result & ~st_r.result_d; // R18
	assign fall = ~cmp_result & st_r.result_d; // R18

	// reserved mode raises nothing, so a stray code cannot flood the handler
	always_comb begin
		unique case (acmp_pkg::event_mode_e'(st_r.ctrl[1:0])) // R12
			acmp_pkg::mode_toggle:  edge_pulse = rise | fall;
			acmp_pkg::mode_reserve: edge_pulse = 1'b0;
			acmp_pkg::mode_fall:    edge_pulse = fall;
			acmp_pkg::mode_rise:    edge_pulse = rise;
		endcase
	end

	// ----------------------------------------------------------------
	// pin input gating
	// ----------------------------------------------------------------
	// pins are asynchronous: only the second stage reaches the gate
	for (genvar g = 0; g < 2; g++) begin : gen_pin_gate
		assign pin_gated[g] = st_r.pin_sync[g] & ~st_r.did0[g]; // R15
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// word addressed: byte address is four times the register index
	assign idx = paddr[9:2];
	assign wr  = psel & penable & pwrite & st_r.pready & pstrb[0];
	assign rd  = psel & ~penable & ~pwrite;
	assign wb  = pwdata[7:0];

	always_comb begin
		hit   = 1'b1;
		rdata = 8'h00;
		unique case (idx)
			acmp_pkg::idx_converter_control_b:       rdata = st_r.conv_b;
			acmp_pkg::idx_comparator_control_status: begin
				rdata = st_r.ctrl;
				rdata[acmp_pkg::ccs_result_bit] = cmp_result;
				rdata[acmp_pkg::ccs_flag_bit]   = st_r.flag;
			end
			acmp_pkg::idx_digital_input_disable_0:   rdata = st_r.did0;
			acmp_pkg::idx_converter_control_a:       rdata = st_r.conv_a;
			acmp_pkg::idx_converter_mux_select:      rdata = st_r.mux_sel;
			acmp_pkg::idx_irq_status:                rdata = {7'h00, st_r.sticky};
			acmp_pkg::idx_irq_clear:                 rdata = 8'h00;
			acmp_pkg::idx_irq_enable:                rdata = {7'h00, st_r.sticky_en};
			acmp_pkg::idx_processor_status_word:     rdata = st_r.psw;
			default:                                 hit   = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync     = {st_r.sync[acmp_pkg::sync_stages-2:0], cmp_raw}; // R01
		st_nxt.result_d = cmp_result; // R18
		st_nxt.pin_meta = {neg_pin_digital, pos_pin_digital};
		st_nxt.pin_sync = st_r.pin_meta;
		st_nxt.pin_in   = pin_gated; // R15

		// zero-wait slave: setup cycle prepares, access cycle completes
		st_nxt.pready  = psel & ~penable;
		st_nxt.pslverr = psel & ~penable & ~hit;
		if (rd) begin
			st_nxt.prdata = {24'h000000, rdata};
		end

		if (wr & hit) begin
			unique case (idx)
				acmp_pkg::idx_converter_control_b:
					st_nxt.conv_b = wb & acmp_pkg::ccb_write_mask;
				acmp_pkg::idx_comparator_control_status:
					st_nxt.ctrl = wb & acmp_pkg::ccs_write_mask; // R06 R16
				acmp_pkg::idx_digital_input_disable_0:
					st_nxt.did0 = wb & acmp_pkg::did_write_mask;
				acmp_pkg::idx_converter_control_a:
					st_nxt.conv_a = wb;
				acmp_pkg::idx_converter_mux_select:
					st_nxt.mux_sel = wb;
				acmp_pkg::idx_irq_enable:
					st_nxt.sticky_en = wb[0];
				acmp_pkg::idx_processor_status_word:
					st_nxt.psw = wb;
				default: ;
			endcase
		end

		// clears first, then hardware set wins the same cycle
		if (wr & (idx == acmp_pkg::idx_comparator_control_status)
			& wb[acmp_pkg::ccs_flag_bit]) begin
			st_nxt.flag = 1'b0; // R11
		end
		if (vector_taken & st_r.irq) begin
			st_nxt.flag = 1'b0; // R10
		end
		if (wr & (idx == acmp_pkg::idx_irq_clear) & wb[0]) begin
			st_nxt.sticky = 1'b0;
		end
		if (edge_pulse) begin
			st_nxt.flag   = 1'b1; // R07
			st_nxt.sticky = 1'b1;
		end

		st_nxt.irq = st_nxt.flag // R08
			& st_nxt.ctrl[acmp_pkg::ccs_irq_enable_bit] // R09
			& st_nxt.psw[acmp_pkg::psw_global_ie_bit];
		st_nxt.sticky_irq = st_nxt.sticky & st_nxt.sticky_en;

		// analog steering
		st_nxt.ana.power_off      = st_nxt.ctrl[acmp_pkg::ccs_power_off_bit]; // R06
		st_nxt.ana.bandgap_select = st_nxt.ctrl[acmp_pkg::ccs_bandgap_bit]; // R04 R05
		if (st_nxt.conv_b[acmp_pkg::ccb_mux_enable_bit]
			& ~st_nxt.conv_a[acmp_pkg::cca_conv_enable_bit]) begin // R17
			st_nxt.ana.neg_select = {1'b0, st_nxt.mux_sel[1:0]}; // R02
		end else begin
			st_nxt.ana.neg_select = acmp_pkg::neg_pin; // R03
		end

		if (srst) begin
			st_nxt           = '0;
			st_nxt.conv_b    = acmp_pkg::reg8_reset;
			st_nxt.ctrl      = acmp_pkg::reg8_reset;
			st_nxt.did0      = acmp_pkg::reg8_reset;
			st_nxt.flag      = acmp_pkg::irq_bits_reset[0];
			st_nxt.ana.neg_select = acmp_pkg::neg_pin;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pready         = st_r.pready;
	assign prdata         = st_r.prdata;
	assign pslverr        = st_r.pslverr;
	assign analog_ctrl    = st_r.ana;
	assign pin_digital_in = st_r.pin_in; // R15
	assign cmp_irq        = st_r.irq;
	assign irq            = st_r.sticky_irq;

endmodule

//--- verif/acmp_chk_assertions.sv
`timescale 1ns/1ps
module acmp_chk (
	input wire logic                   ref_clk,
	input wire logic                   srst,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [9:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   pos_pin_digital,
	input wire logic                   neg_pin_digital,
	input wire logic                   vector_taken,
	input wire acmp_pkg::analog_ctrl_s analog_ctrl,
	input wire logic [1:0]             pin_digital_in,
	input wire logic                   cmp_irq
);
	// ------------------------------
	// bus and event relations
	// ------------------------------
	wire setup = psel && !penable;
	wire wr    = psel && penable && pwrite;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	setup_answer_a: assert property (setup |=> pready)
		else $error("no answer after setup");
	ready_cause_a: assert property (pready |-> $past(setup))
		else $error("answer without setup");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error outside answer");
	// an input never passes a high level that its pin did not have three cycles before
	pin_gate_a: assert property ((pin_digital_in & ~{$past(neg_pin_digital, 3),
		$past(pos_pin_digital, 3)}) == 2'h0)
		else $error("pin input not gated");
	pin_off_a: assert property (wr && pready && paddr == 10'h050 && pstrb[0]
		&& pwdata[1:0] == 2'h3 |-> ##2 pin_digital_in == 2'h0)
		else $error("disabled pins still pass a level");
	neg_legal_a: assert property (analog_ctrl.neg_select <= 3'h4)
		else $error("negative select out of range");
	ctrl_hold_a: assert property (!$stable(analog_ctrl) |-> $past(wr))
		else $error("analog control moved without write");
	vector_clear_a: assert property (vector_taken && cmp_irq |-> ##[1:2] !cmp_irq)
		else $error("vector did not clear request");
	ie_off_a: assert property (wr && pready && paddr == 10'h020 && pstrb[0]
		&& !pwdata[3] |-> ##2 !cmp_irq)
		else $error("request stayed after enable cleared");
endmodule
bind analog_comparator_control acmp_chk acmp_chk_i (.ref_clk, .srst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .pos_pin_digital,
	.neg_pin_digital, .vector_taken, .analog_ctrl, .pin_digital_in, .cmp_irq);

//--- verif/analog_side.sv
`timescale 1ns/1ps
module analog_side (
	input  wire logic       ref_clk,
	input  wire logic       lvl,
	input  wire logic [1:0] pins,
	input  wire logic       take_en,
	input  wire logic       cmp_irq,
	output logic            cmp_raw,
	output logic [1:0]      pin_lvl,
	output logic            vector_taken
);
	// ------------------------------
	// pins and vector acknowledge
	// ------------------------------
	initial begin
		{cmp_raw, pin_lvl, vector_taken} = 4'h0;
	end
	always @(posedge ref_clk) begin
		cmp_raw <= lvl;
		pin_lvl <= pins;
		// one pulse per pending request, like a vector fetch
		vector_taken <= take_en && cmp_irq && !vector_taken;
	end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic                   ref_clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic                   lvl, take_en, cmp_raw, vt, cmp_irq, irq;
	logic [9:0]             paddr;
	logic [31:0]            pwdata, prdata, rd_v;
	logic [1:0]             pins, pin_lvl, pdi;
	acmp_pkg::analog_ctrl_s ac;
	int                     failures, n_checks;
	analog_comparator_control analog_comparator_control_i (.ref_clk, .srst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr,
		.cmp_raw, .pos_pin_digital(pin_lvl[0]), .neg_pin_digital(pin_lvl[1]),
		.vector_taken(vt), .analog_ctrl(ac), .pin_digital_in(pdi), .cmp_irq, .irq);
	analog_side analog_side_i (.ref_clk, .lvl, .pins, .take_en, .cmp_irq, .cmp_raw,
		.pin_lvl, .vector_taken(vt));
	// ------------------------------
	// bus tasks and checks
	// ------------------------------
	task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
		n_checks++;
		if (got !== e) begin
			failures++;
			$display("wrong value %s exp %h seen %h", nm, e, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// two idle edges after release so registered outputs have landed
	task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd_v = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		cyc(2);
	endtask
	task rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
		xfer(1'h0, i, 8'h00);
		chk(nm, rd_v, e);
	endtask
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		cyc(20000);
		failures++;
		test_done;
	end
	initial begin
		{srst, psel, penable, pwrite, lvl, take_en} = 6'h20;
		{paddr, pwdata, pins, failures, n_checks} = '0;
		cyc(20);
		srst <= 1'h0;
		rdc("convb", 8'h03, 32'h00);
		rdc("ctrl", 8'h08, 32'h00);
		rdc("did0", 8'h14, 32'h00);
		rdc("status", 8'h30, 32'h00);
		xfer(1'h0, 8'h10, 8'h00);
		chk("slverr", {31'h0, err}, 32'h1);
		$display("test reset done");
		xfer(1'h1, 8'h08, 8'hC7);
		rdc("ctrl", 8'h08, 32'hC3);
		chk("poweroff", {31'h0, ac.power_off}, 32'h1);
		chk("bandgap", {31'h0, ac.bandgap_select}, 32'h1);
		xfer(1'h1, 8'h08, 8'h00);
		chk("bandgap", {31'h0, ac.bandgap_select}, 32'h0);
		xfer(1'h1, 8'h03, 8'h40);
		for (int c = 0; c < 4; c++) begin
			xfer(1'h1, 8'h21, c[7:0]);
			chk("negsel", {29'h0, ac.neg_select}, c);
		end
		xfer(1'h1, 8'h20, 8'h80);
		chk("negsel", {29'h0, ac.neg_select}, 32'h4);
		xfer(1'h1, 8'h20, 8'h00);
		xfer(1'h1, 8'h03, 8'h00);
		chk("negsel", {29'h0, ac.neg_select}, 32'h4);
		lvl <= 1'h1;
		cyc(4);
		rdc("result", 8'h08, 32'h30);
		lvl <= 1'h0;
		cyc(4);
		$display("test control done");
		for (int m = 0; m < 4; m++) begin
			xfer(1'h1, 8'h08, 8'h10 | m[7:0]);
			lvl <= 1'h1;
			cyc(6);
			rdc("rise", 8'h08, 32'h20 | m | ((m == 0 || m == 3) ? 32'h10 : 32'h0));
			xfer(1'h1, 8'h08, 8'h10 | m[7:0]);
			lvl <= 1'h0;
			cyc(6);
			rdc("fall", 8'h08, m | ((m == 0 || m == 2) ? 32'h10 : 32'h0));
			xfer(1'h1, 8'h08, m[7:0]);
			rdc("keep", 8'h08, m | ((m == 0 || m == 2) ? 32'h10 : 32'h0));
		end
		$display("test modes done");
		xfer(1'h1, 8'h33, 8'h80);
		xfer(1'h1, 8'h32, 8'h01);
		xfer(1'h1, 8'h08, 8'h1B);
		lvl <= 1'h1;
		cyc(6);
		chk("cmpirq", {31'h0, cmp_irq}, 32'h1);
		chk("irq", {31'h0, irq}, 32'h1);
		xfer(1'h1, 8'h08, 8'h03);
		chk("cmpirq", {31'h0, cmp_irq}, 32'h0);
		xfer(1'h1, 8'h08, 8'h0B);
		chk("cmpirq", {31'h0, cmp_irq}, 32'h1);
		take_en <= 1'h1;
		cyc(4);
		take_en <= 1'h0;
		chk("cmpirq", {31'h0, cmp_irq}, 32'h0);
		rdc("ctrl", 8'h08, 32'h2B);
		rdc("status", 8'h30, 32'h01);
		xfer(1'h1, 8'h32, 8'h00);
		chk("irq", {31'h0, irq}, 32'h0);
		xfer(1'h1, 8'h32, 8'h01);
		chk("irq", {31'h0, irq}, 32'h1);
		xfer(1'h1, 8'h31, 8'h01);
		chk("irq", {31'h0, irq}, 32'h0);
		rdc("status", 8'h30, 32'h00);
		rdc("clear", 8'h31, 32'h00);
		$display("test interrupt done");
		pins <= 2'h3;
		cyc(5);
		chk("pins", {30'h0, pdi}, 32'h3);
		xfer(1'h1, 8'h14, 8'h03);
		chk("pins", {30'h0, pdi}, 32'h0);
		xfer(1'h1, 8'h14, 8'h01);
		chk("pins", {30'h0, pdi}, 32'h2);
		rdc("did0", 8'h14, 32'h01);
		$display("test pins done");
		test_done;
	end
endmodule
